// *** pac_classifier.sv ***
`timescale 1ns/1ps
`include "pac_consts.svh"
// Functional notes
// - an address is one short word or two long words in sequence
// - words are classified by value into long1, short, long3, long4, long2
// - all-zero and all-ones words are idle and never match
// - service, network, temporary, operator and reserved short ranges are classified
// - long pairs accepted only as 1-2, 1-3, 1-4, 2-3, 2-4
// - single-phase addresses search only their assigned phase
// - any-phase accepts any phase, one phase per message per frame
// - all-phase may span phases in a frame, searched in every phase
// - battery cycle 0..7 searches assigned frame then every 2^b frames
// - standard rule: phase from bits 3:2, frame from bits 10:4
// - missing battery cycle defaults to 4, one search per 16 frames
// - non-standard addresses take an explicit frame 0..127
// - letters A-L standard derived, U-Z explicit configuration
// - standard subtract 0..3 by address index; U-X select phases 0..3
// - numbers below 2031615 short, above 2101248 long, between rejected
// - short form seven digits, set 1-2 nine, other long ten
// - extended roaming form: ten digits plus leading letter P-S
module pac_classifier (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  input wire logic i_word_valid,
  input wire logic [20:0] i_word,
  input wire logic [1:0] i_rx_phase,
  input wire logic [6:0] i_rx_frame,
  input wire logic i_frame_start,
  input wire logic [32:0] i_subscriber_address_code,
  input wire logic [4:0] i_address_type_letter,
  input wire logic [2:0] i_roam_letter,
  input wire logic i_batt_given,
  input wire logic [2:0] i_batt_cycle,
  input wire logic i_frame_given,
  input wire logic [6:0] i_cfg_frame,
  input wire logic [20:0] i_match_w1,
  input wire logic [20:0] i_match_w2,
  input wire logic i_match_long,
  output logic o_class_valid,
  output logic [3:0] o_word_class,
  output logic o_long_pair_ok,
  output logic o_unmatched,
  output logic o_hit,
  output logic o_search_now,
  output logic [1:0] o_assigned_phase,
  output logic [6:0] o_assigned_frame,
  output logic [2:0] o_batt_used,
  output logic [1:0] o_phase_mode,
  output logic o_cfg_reject,
  output logic [3:0] o_digit_count,
  output logic o_roaming
);
  pac_pkg::pac_class_e cls;
  pac_pkg::pac_state_e state_reg;
  logic [3:0] first_cls_reg;
  logic [20:0] first_word_reg;
  logic pair_ok;
  logic idle_w;
  logic long_w;
  logic std_type;
  logic [1:0] sub_amt;
  logic [32:0] adj_addr;
  logic [1:0] phase_next;
  logic [6:0] frame_next;
  logic [2:0] batt_next;
  logic [1:0] mode_next;
  logic [6:0] frame_mask;
  logic in_window;
  logic msg_phase_lock_reg;
  logic [1:0] msg_phase_reg;
  logic cfg_reject_next;
  logic [3:0] digits_next;

  always_comb begin
    idle_w = (i_word == `PAC_IDLE_LO) || (i_word == `PAC_IDLE_HI);
    if (idle_w) cls = pac_pkg::PAC_IDLE;
    else if (i_word <= `PAC_L1_HI) cls = pac_pkg::PAC_LONG1;
    else if (i_word <= `PAC_SHORT_HI) cls = pac_pkg::PAC_SHORT;
    else if (i_word <= `PAC_L3_HI) cls = pac_pkg::PAC_LONG3;
    else if (i_word <= `PAC_L4_HI) cls = pac_pkg::PAC_LONG4;
    else if (i_word <= `PAC_RSV1_HI) cls = pac_pkg::PAC_RESERVED;
    else if (i_word <= `PAC_INFO_HI) cls = pac_pkg::PAC_INFO;
    else if (i_word <= `PAC_NET_HI) cls = pac_pkg::PAC_NETWORK;
    else if (i_word <= `PAC_TEMP_HI) cls = pac_pkg::PAC_TEMPORARY;
    else if (i_word <= `PAC_OPER_HI) cls = pac_pkg::PAC_OPERATOR;
    else if (i_word <= `PAC_RSV2_HI) cls = pac_pkg::PAC_RESERVED;
    else cls = pac_pkg::PAC_LONG2;
  end

  always_comb begin
    long_w = (cls == pac_pkg::PAC_LONG3) || (cls == pac_pkg::PAC_LONG4);
    pair_ok = 1'b0;
    if (first_cls_reg == 4'(pac_pkg::PAC_LONG1)) pair_ok = long_w || (cls == pac_pkg::PAC_LONG2);
    else if (first_cls_reg == 4'(pac_pkg::PAC_LONG2)) pair_ok = long_w;
  end

  // pairing of long first and second words
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      state_reg <= pac_pkg::PAC_ST_WAIT;
      first_cls_reg <= 4'h0;
      first_word_reg <= 21'h00_0000;
    end else if (i_ce && i_word_valid) begin
      case (state_reg)
        pac_pkg::PAC_ST_WAIT: begin
          if (cls == pac_pkg::PAC_LONG1 || cls == pac_pkg::PAC_LONG2) begin
            state_reg <= pac_pkg::PAC_ST_SECOND;
            first_cls_reg <= 4'(cls);
            first_word_reg <= i_word;
          end
        end
        pac_pkg::PAC_ST_SECOND: begin
          // a long2 after long1 closes the pair; a long1/long2 that fails pairing restarts
          if (!pair_ok && (cls == pac_pkg::PAC_LONG1 || cls == pac_pkg::PAC_LONG2)) begin
            first_cls_reg <= 4'(cls);
            first_word_reg <= i_word;
          end else begin
            state_reg <= pac_pkg::PAC_ST_WAIT;
            first_cls_reg <= 4'h0;
          end
        end
        default: state_reg <= pac_pkg::PAC_ST_WAIT;
      endcase
    end
  end

  // word result outputs
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      o_class_valid <= 1'b0;
      o_word_class <= 4'h0;
      o_long_pair_ok <= 1'b0;
      o_unmatched <= 1'b0;
      o_hit <= 1'b0;
    end else if (i_ce) begin
      o_class_valid <= i_word_valid;
      o_word_class <= 4'(cls);
      o_long_pair_ok <= i_word_valid && (state_reg == pac_pkg::PAC_ST_SECOND) && pair_ok;
      o_unmatched <= i_word_valid && ((cls == pac_pkg::PAC_RESERVED) || idle_w ||
                     ((state_reg == pac_pkg::PAC_ST_SECOND) && !pair_ok));
      o_hit <= 1'b0;
      if (i_word_valid && !idle_w && in_window && !cfg_reject_next) begin
        if (!i_match_long && (cls != pac_pkg::PAC_RESERVED) && (cls != pac_pkg::PAC_LONG1) &&
            (cls != pac_pkg::PAC_LONG2) && (cls != pac_pkg::PAC_LONG3) && (cls != pac_pkg::PAC_LONG4))
          o_hit <= (i_word == i_match_w1);
        else if (i_match_long && (state_reg == pac_pkg::PAC_ST_SECOND) && pair_ok)
          o_hit <= (first_word_reg == i_match_w1) && (i_word == i_match_w2);
      end
    end
  end

  // address configuration decode
  always_comb begin
    std_type = (i_address_type_letter <= 5'd11);
    sub_amt = i_address_type_letter[1:0];
    adj_addr = i_subscriber_address_code - {31'h0, sub_amt};
    mode_next = pac_pkg::PAC_SINGLE;
    phase_next = 2'h0;
    frame_next = 7'h00;
    if (std_type) begin
      mode_next = 2'(i_address_type_letter[3:2]); // A-D single, E-H any, I-L all
      phase_next = adj_addr[`PAC_PHASE_LSB +: 2];
      frame_next = adj_addr[`PAC_FRAME_LSB +: 7];
      if (i_frame_given) frame_next = i_cfg_frame;
    end else begin
      // U..X = 20..23 single with phase, Y = 24 any, Z = 25 all
      if (i_address_type_letter <= 5'd23) begin
        mode_next = pac_pkg::PAC_SINGLE;
        phase_next = i_address_type_letter[1:0];
      end else if (i_address_type_letter == 5'd24) mode_next = pac_pkg::PAC_ANY;
      else mode_next = pac_pkg::PAC_ALL;
      frame_next = i_cfg_frame;
    end
    batt_next = i_batt_given ? i_batt_cycle : `PAC_BATT_DEFAULT;
    cfg_reject_next = (i_subscriber_address_code >= `PAC_SHORT_MAX_NUM) &&
                      (i_subscriber_address_code < `PAC_LONG_MIN_NUM);
    cfg_reject_next = cfg_reject_next || (i_subscriber_address_code == 33'h0_0000_0000) ||
                      (i_address_type_letter > 5'd25) ||
                      ((i_address_type_letter > 5'd11) && (i_address_type_letter < 5'd20));
    if (i_subscriber_address_code < `PAC_SHORT_MAX_NUM) digits_next = 4'h7;
    else if (i_subscriber_address_code < 33'h0_3B9A_CA00) digits_next = 4'h9;
    else digits_next = 4'hA;
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      o_assigned_phase <= 2'h0;
      o_assigned_frame <= 7'h00;
      o_batt_used <= `PAC_BATT_DEFAULT;
      o_phase_mode <= 2'h0;
      o_cfg_reject <= 1'b0;
      o_digit_count <= 4'h7;
      o_roaming <= 1'b0;
    end else if (i_ce) begin
      o_assigned_phase <= phase_next;
      o_assigned_frame <= frame_next;
      o_batt_used <= batt_next;
      o_phase_mode <= mode_next;
      o_digit_count <= digits_next;
      o_roaming <= (i_roam_letter != 3'h0) && (digits_next == 4'hA);
      o_cfg_reject <= cfg_reject_next || ((i_roam_letter != 3'h0) && (digits_next != 4'hA));
    end
  end

  // search window: frame match under the battery mask plus phase policy
  always_comb begin
    frame_mask = ~((7'h7F << batt_next) | 7'h00); // low b bits set
    in_window = ((i_rx_frame & frame_mask) == (frame_next & frame_mask));
    case (mode_next)
      pac_pkg::PAC_SINGLE: in_window = in_window && (i_rx_phase == phase_next);
      pac_pkg::PAC_ANY: in_window = in_window && (!msg_phase_lock_reg || (i_rx_phase == msg_phase_reg));
      default: in_window = in_window;
    endcase
  end

  // any-phase: first phase that yields a hit owns the message for the frame
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      msg_phase_lock_reg <= 1'b0;
      msg_phase_reg <= 2'h0;
    end else if (i_ce) begin
      if (i_frame_start) msg_phase_lock_reg <= 1'b0;
      else if (o_hit && !msg_phase_lock_reg && (o_phase_mode == 2'(pac_pkg::PAC_ANY))) begin
        msg_phase_lock_reg <= 1'b1;
        msg_phase_reg <= i_rx_phase;
      end
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) o_search_now <= 1'b0;
    else if (i_ce) o_search_now <= in_window;
  end

  chk_idle_no_hit: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    i_ce && i_word_valid && idle_w |=> !o_hit) else $error("idle word gave a hit");
  chk_reserved_unmatched: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    i_ce && i_word_valid && cls == pac_pkg::PAC_RESERVED |=> o_unmatched && !o_hit)
    else $error("reserved word not unmatched");
  chk_pair_illegal: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    i_ce && i_word_valid && first_cls_reg == 4'(pac_pkg::PAC_LONG2) && cls == pac_pkg::PAC_LONG2
    |=> !o_long_pair_ok) else $error("2-2 pair accepted");
  chk_default_batt: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    i_ce && !i_batt_given |=> o_batt_used == 3'h4) else $error("default battery not 4");
  chk_std_phase: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    i_ce && i_address_type_letter == 5'd0 |=> o_assigned_phase == $past(i_subscriber_address_code[3:2]))
    else $error("standard phase wrong");
  chk_ux_phase: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    i_ce && i_address_type_letter == 5'd22 |=> o_assigned_phase == 2'h2 && o_phase_mode == 2'h0)
    else $error("W letter phase wrong");
  chk_gap_reject: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    i_ce && i_subscriber_address_code == 33'h0_001F_8000 |=> o_cfg_reject)
    else $error("gap number accepted");
  chk_single_phase: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    i_ce && mode_next == pac_pkg::PAC_SINGLE && i_rx_phase != phase_next |=> !o_search_now)
    else $error("single phase searched wrong phase");

  // long pairing steps as the word source delivers them: a word, one idle cycle, the next word
  sequence s_first_long1;
    i_ce && i_word_valid && (cls == pac_pkg::PAC_LONG1) && (state_reg == pac_pkg::PAC_ST_WAIT);
  endsequence
  sequence s_word_gap;
    i_ce && !i_word_valid;
  endsequence
  sequence s_second_long2;
    i_ce && i_word_valid && (cls == pac_pkg::PAC_LONG2);
  endsequence
  sequence s_second_long34;
    i_ce && i_word_valid && ((cls == pac_pkg::PAC_LONG3) || (cls == pac_pkg::PAC_LONG4));
  endsequence
  sequence s_second_long1;
    i_ce && i_word_valid && (cls == pac_pkg::PAC_LONG1);
  endsequence

  chk_valid_follows: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    i_ce |=> o_class_valid == $past(i_word_valid))
    else $error("class valid does not follow word valid");

  chk_pair_one_two: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    s_first_long1 ##1 s_word_gap ##1 s_second_long2 |=> o_long_pair_ok)
    else $error("1-2 pair refused");

  chk_pair_one_three: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    s_first_long1 ##1 s_word_gap ##1 s_second_long34 |=> o_long_pair_ok)
    else $error("1-3 or 1-4 pair refused");

  chk_pair_one_one: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    s_first_long1 ##1 s_word_gap ##1 s_second_long1 |=> !o_long_pair_ok && o_unmatched)
    else $error("1-1 pair not unmatched");

  chk_class_long1: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    i_ce && i_word >= 21'h00_0001 && i_word <= 21'h00_8000 |=> o_word_class == 4'h1)
    else $error("long1 range misclassified");

  chk_class_short: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    i_ce && i_word >= 21'h00_8001 && i_word <= 21'h1E_0000 |=> o_word_class == 4'h2)
    else $error("short range misclassified");

  chk_class_long2: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    i_ce && i_word >= 21'h1F_7FFF && i_word <= 21'h1F_FFFE |=> o_word_class == 4'hA)
    else $error("long2 range misclassified");

  chk_class_operator: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    i_ce && i_word >= 21'h1F_7810 && i_word <= 21'h1F_781F |=> o_word_class == 4'h9)
    else $error("operator range misclassified");

  chk_idle_ones: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    i_ce && i_word_valid && i_word == 21'h1F_FFFF |=> o_unmatched && !o_hit)
    else $error("all-ones word not idle");

  chk_any_lock: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    i_ce && msg_phase_lock_reg && mode_next == pac_pkg::PAC_ANY && i_rx_phase != msg_phase_reg
    |=> !o_search_now)
    else $error("any-phase message searched in second phase");

  chk_batt_given: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    i_ce && i_batt_given |=> o_batt_used == $past(i_batt_cycle))
    else $error("given battery cycle not used");

  chk_frame_explicit: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    i_ce && i_address_type_letter >= 5'd20 && i_address_type_letter <= 5'd25
    |=> o_assigned_frame == $past(i_cfg_frame))
    else $error("non-standard frame not explicit");

  chk_mode_any: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    i_ce && i_address_type_letter >= 5'd4 && i_address_type_letter <= 5'd7 |=> o_phase_mode == 2'h1)
    else $error("letters E-H not any-phase");

  chk_long_accept: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    i_ce && i_subscriber_address_code >= 33'h0_0020_1001 && i_address_type_letter <= 5'd11 &&
    i_roam_letter == 3'h0 |=> !o_cfg_reject)
    else $error("long number rejected");

  chk_digits_short: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    i_ce && i_subscriber_address_code < 33'h0_001E_FFFF |=> o_digit_count == 4'h7)
    else $error("short number not seven digits");

  chk_roaming_ten: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    i_ce && i_roam_letter != 3'h0 && i_subscriber_address_code >= 33'h0_3B9A_CA00 |=> o_roaming)
    else $error("roaming form not flagged");
endmodule : pac_classifier

// *** pac_consts.svh ***
`ifndef PAC_CONSTS_SVH
`define PAC_CONSTS_SVH
`define PAC_IDLE_LO 21'h00_0000
`define PAC_IDLE_HI 21'h1F_FFFF
`define PAC_L1_HI 21'h00_8000
`define PAC_SHORT_HI 21'h1E_0000
`define PAC_L3_HI 21'h1E_8000
`define PAC_L4_HI 21'h1F_0000
`define PAC_RSV1_HI 21'h1F_27FF
`define PAC_INFO_HI 21'h1F_67FF
`define PAC_NET_HI 21'h1F_77FF
`define PAC_TEMP_HI 21'h1F_780F
`define PAC_OPER_HI 21'h1F_781F
`define PAC_RSV2_HI 21'h1F_7FFE
`define PAC_SHORT_MAX_NUM 33'h0_001E_FFFF
`define PAC_LONG_MIN_NUM 33'h0_0020_1001
`define PAC_BATT_DEFAULT 3'h4
`define PAC_PHASE_LSB 2
`define PAC_FRAME_LSB 4
`endif

// *** pac_pkg.sv ***
package pac_pkg;
  typedef enum logic [3:0] {
    PAC_IDLE = 4'h0, PAC_LONG1 = 4'h1, PAC_SHORT = 4'h2, PAC_LONG3 = 4'h3,
    PAC_LONG4 = 4'h4, PAC_RESERVED = 4'h5, PAC_INFO = 4'h6, PAC_NETWORK = 4'h7,
    PAC_TEMPORARY = 4'h8, PAC_OPERATOR = 4'h9, PAC_LONG2 = 4'hA
  } pac_class_e;
  typedef enum logic [1:0] {PAC_SINGLE = 2'h0, PAC_ANY = 2'h1, PAC_ALL = 2'h2} pac_mode_e;
  typedef enum logic [1:0] {
    PAC_ST_WAIT = 2'b01,
    PAC_ST_SECOND = 2'b10
  } pac_state_e;
endpackage : pac_pkg

// *** pac_word_src.sv ***
`timescale 1ns/1ps
// stands in for the channel decoder that hands over one code word per valid pulse
module pac_word_src (
  input wire logic i_clk,
  output logic o_valid,
  output logic [20:0] o_word
);
  initial begin
    o_valid = 1'b0;
    o_word = 21'h15_5555;
  end
  // word is only meaningful while valid; afterwards it shows the inverse
  task automatic send(input logic [20:0] w);
    @(posedge i_clk);
    o_valid <= 1'b1;
    o_word <= w;
    @(posedge i_clk);
    o_valid <= 1'b0;
    o_word <= ~w;
  endtask : send
endmodule : pac_word_src

// *** tb_paging_address_classifier.sv ***
`timescale 1ns/1ps
module tb_paging_address_classifier;
  logic i_sys_clk, i_rst_n, i_ce, wv, i_frame_start, i_batt_given, i_frame_given, i_match_long;
  logic [20:0] wd, i_match_w1, i_match_w2;
  logic [1:0] i_rx_phase, o_assigned_phase, o_phase_mode;
  logic [6:0] i_rx_frame, i_cfg_frame, o_assigned_frame;
  logic [32:0] i_code;
  logic [4:0] i_letter;
  logic [2:0] i_roam_letter, i_batt_cycle, o_batt_used;
  logic o_class_valid, o_long_pair_ok, o_unmatched, o_hit, o_search_now, o_cfg_reject, o_roaming;
  logic [3:0] o_word_class, o_digit_count;
  int fail_count = 0;
  int checked = 0;
  logic [20:0] wtab [24] = '{21'h00_0000, 21'h00_0001, 21'h00_8000, 21'h00_8001, 21'h1E_0000, 21'h1E_0001,
    21'h1E_8000, 21'h1E_8001, 21'h1F_0000, 21'h1F_0001, 21'h1F_27FF, 21'h1F_2800, 21'h1F_67FF, 21'h1F_6800,
    21'h1F_77FF, 21'h1F_7800, 21'h1F_780F, 21'h1F_7810, 21'h1F_781F, 21'h1F_7820, 21'h1F_7FFE, 21'h1F_7FFF,
    21'h1F_FFFE, 21'h1F_FFFF};
  logic [3:0] ctab [24] = '{4'h0, 4'h1, 4'h1, 4'h2, 4'h2, 4'h3, 4'h3, 4'h4, 4'h4, 4'h5, 4'h5, 4'h6, 4'h6,
    4'h7, 4'h7, 4'h8, 4'h8, 4'h9, 4'h9, 4'h5, 4'h5, 4'hA, 4'hA, 4'h0};
  logic [20:0] ptab [15] = '{21'h00_0001, 21'h1F_8000, 21'h00_0001, 21'h1E_0001, 21'h00_0001, 21'h1E_8001,
    21'h1F_8000, 21'h1E_0001, 21'h1F_8000, 21'h1E_8001, 21'h00_0001, 21'h00_8001, 21'h00_0001, 21'h00_0002,
    21'h1E_0001};
  logic [14:0] pok = 15'b010_1010_1010_0001;
  logic [14:0] pbad = 15'b000_0000_0000_1010;
  logic [4:0] ltab [6] = '{5'h00, 5'h04, 5'h08, 5'h14, 5'h18, 5'h19};
  logic [1:0] mtab [6] = '{2'h0, 2'h1, 2'h2, 2'h0, 2'h1, 2'h2};

  pac_word_src u_src (.i_clk(i_sys_clk), .o_valid(wv), .o_word(wd));
  pac_classifier u_dut (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_ce(i_ce), .i_word_valid(wv), .i_word(wd),
    .i_rx_phase(i_rx_phase), .i_rx_frame(i_rx_frame), .i_frame_start(i_frame_start),
    .i_subscriber_address_code(i_code), .i_address_type_letter(i_letter), .i_roam_letter(i_roam_letter),
    .i_batt_given(i_batt_given), .i_batt_cycle(i_batt_cycle), .i_frame_given(i_frame_given),
    .i_cfg_frame(i_cfg_frame), .i_match_w1(i_match_w1), .i_match_w2(i_match_w2), .i_match_long(i_match_long),
    .o_class_valid(o_class_valid), .o_word_class(o_word_class), .o_long_pair_ok(o_long_pair_ok),
    .o_unmatched(o_unmatched), .o_hit(o_hit), .o_search_now(o_search_now), .o_assigned_phase(o_assigned_phase),
    .o_assigned_frame(o_assigned_frame), .o_batt_used(o_batt_used), .o_phase_mode(o_phase_mode),
    .o_cfg_reject(o_cfg_reject), .o_digit_count(o_digit_count), .o_roaming(o_roaming));

  initial begin
    i_sys_clk = 1'b0;
    forever #25 i_sys_clk = ~i_sys_clk;
  end

  task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : end_of_test

  task automatic put(input logic [20:0] w);
    u_src.send(w);
    @(negedge i_sys_clk);
    chk(o_class_valid, 1);
  endtask : put

  task automatic cfg(input logic [32:0] code, input logic [4:0] letter);
    @(posedge i_sys_clk);
    i_code <= code;
    i_letter <= letter;
    repeat (2) @(posedge i_sys_clk);
    @(negedge i_sys_clk);
  endtask : cfg

  task automatic test_classes();
    for (int i = 0; i < 24; i++) begin
      put(wtab[i]);
      chk(o_word_class, ctab[i]);
      if (ctab[i] == 4'h0 || ctab[i] == 4'h5) chk(o_unmatched, 1);
    end
  endtask : test_classes

  task automatic test_pairs();
    for (int i = 0; i < 15; i++) begin
      put(ptab[i]);
      chk(o_long_pair_ok, pok[14 - i]);
      if (pbad[14 - i]) chk(o_unmatched, 1);
    end
  endtask : test_pairs

  task automatic test_config();
    cfg(33'h0_0000_0024, 5'h00);
    chk({o_assigned_phase, o_assigned_frame, o_batt_used}, {2'h1, 7'h02, 3'h4});
    cfg(33'h0_0000_0024, 5'h01);
    chk({o_assigned_phase, o_assigned_frame}, {2'h0, 7'h02});
    cfg(33'h0_0000_0027, 5'h03);
    chk({o_assigned_phase, o_assigned_frame}, {2'h1, 7'h02});
    for (int i = 0; i < 6; i++) begin
      cfg(33'h0_0000_0024, ltab[i]);
      chk(o_phase_mode, mtab[i]);
    end
    i_frame_given <= 1'b1;
    i_cfg_frame <= 7'h55;
    i_batt_given <= 1'b1;
    i_batt_cycle <= 3'h7;
    cfg(33'h0_0000_0024, 5'h14);
    chk({o_assigned_phase, o_assigned_frame, o_batt_used}, {2'h0, 7'h55, 3'h7});
    cfg(33'h0_0000_0024, 5'h17);
    chk(o_assigned_phase, 3);
    i_frame_given <= 1'b0;
    cfg(33'h0_001E_FFFE, 5'h00);
    chk({o_cfg_reject, o_digit_count, o_roaming}, {1'b0, 4'h7, 1'b0});
    cfg(33'h0_001E_FFFF, 5'h00);
    chk(o_cfg_reject, 1);
    cfg(33'h0_0020_1000, 5'h00);
    chk(o_cfg_reject, 1);
    cfg(33'h0_0020_1001, 5'h00);
    chk({o_cfg_reject, o_digit_count}, {1'b0, 4'h9});
    i_roam_letter <= 3'h3;
    cfg(33'h0_3B9A_CA00, 5'h00);
    chk({o_digit_count, o_roaming}, {4'hA, 1'b1});
    i_roam_letter <= 3'h0;
  endtask : test_config

  task automatic hit(input logic [1:0] ph, input logic [6:0] fr, input logic exp);
    @(posedge i_sys_clk);
    i_rx_phase <= ph;
    i_rx_frame <= fr;
    put(21'h00_8001);
    chk(o_hit, exp);
    chk(o_search_now, exp);
  endtask : hit

  task automatic test_hits();
    i_batt_cycle <= 3'h0;
    cfg(33'h0_0000_0024, 5'h00);
    hit(2'h1, 7'h00, 1'b1);
    hit(2'h2, 7'h00, 1'b0);
    cfg(33'h0_0000_0024, 5'h04);
    hit(2'h2, 7'h00, 1'b1);
    hit(2'h3, 7'h00, 1'b0);
    @(posedge i_sys_clk);
    i_frame_start <= 1'b1;
    @(posedge i_sys_clk);
    i_frame_start <= 1'b0;
    hit(2'h3, 7'h01, 1'b1);
    cfg(33'h0_0000_0024, 5'h08);
    hit(2'h0, 7'h02, 1'b1);
    i_batt_cycle <= 3'h2;
    cfg(33'h0_0000_0024, 5'h00);
    hit(2'h1, 7'h06, 1'b1);
    hit(2'h1, 7'h07, 1'b0);
    i_match_w1 <= 21'h1F_0001;
    put(21'h1F_0001);
    chk({o_hit, o_unmatched}, {1'b0, 1'b1});
    // clock enable low: a word offered meanwhile must leave no trace
    @(posedge i_sys_clk);
    i_ce <= 1'b0;
    u_src.send(21'h00_8001);
    @(negedge i_sys_clk);
    chk(o_class_valid, 0);
    i_ce <= 1'b1;
  endtask : test_hits

  initial begin
    i_rst_n = 1'b0;
    i_ce = 1'b1;
    i_rx_phase = 2'h0;
    i_rx_frame = 7'h00;
    i_frame_start = 1'b0;
    i_code = 33'h0_0000_0024;
    i_letter = 5'h00;
    i_roam_letter = 3'h0;
    i_batt_given = 1'b0;
    i_batt_cycle = 3'h0;
    i_frame_given = 1'b0;
    i_cfg_frame = 7'h00;
    i_match_w1 = 21'h00_8001;
    i_match_w2 = 21'h00_0000;
    i_match_long = 1'b0;
    repeat (16) @(posedge i_sys_clk);
    @(negedge i_sys_clk);
    chk({o_batt_used, o_digit_count, o_hit, o_class_valid}, {3'h4, 4'h7, 1'b0, 1'b0});
    @(posedge i_sys_clk);
    i_rst_n <= 1'b1;
    test_classes();
    test_pairs();
    test_config();
    test_hits();
    end_of_test();
  end

  // the whole run needs well under 1000 cycles
  initial begin
    repeat (5000) @(posedge i_sys_clk);
    fail_count++;
    end_of_test();
  end
endmodule : tb_paging_address_classifier
